// [bench/tweep_chk.sv]
// Checker for the two-wire bus between master and memory slave
`timescale 1ns/10ps
`default_nettype none
module tweep_chk #(
   parameter int WR_CYC = tweep_pkg::WR_CYC,
   parameter int QTR_CYC = tweep_pkg::QTR_CYC
) (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic clk_link,
   input wire logic nrst,
   // Bus
   input wire logic scl_oe,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda,
   // Slave status
   input wire logic busy_q
);
   // ****************
   // Helper state
   // ****************
   logic scl_q, sda_q, start_ev, stop_ev, frame_q, frame_d;
   // Wide enough for the full-length write cycle
   logic [17:0] bcnt_q, bcnt_d;
   logic [15:0] hcnt_q, hcnt_d;
   logic [3:0] age_q, age_d;
   always_comb begin
      start_ev = scl_q & scl & sda_q & ~sda;
      stop_ev = scl_q & scl & ~sda_q & sda;
      frame_d = start_ev | (frame_q & ~stop_ev);
      bcnt_d = busy_q ? bcnt_q + 18'h1 : 18'h0;
      age_d = stop_ev ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
   end
   always_ff @(posedge clk_link or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         frame_q <= 1'h0;
         bcnt_q <= 18'h0;
         age_q <= 4'hf;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         frame_q <= frame_d;
         bcnt_q <= bcnt_d;
         age_q <= age_d;
      end
   end
   always_comb begin
      hcnt_d = scl_oe ? hcnt_q + 16'h1 : 16'h0;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hcnt_q <= 16'h0;
      end else begin
         hcnt_q <= hcnt_d;
      end
   end
   // ****************
   // Properties
   // ****************
   slave_sda_low_a: assert property (
      @(posedge clk_link) disable iff (!nrst) $changed(sda_s_oe) |-> !scl
   ) else $error("slave moved SDA while SCL high");
   stop_released_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      stop_ev |-> !sda_s_oe && !$past(sda_s_oe)
   ) else $error("stop while slave held SDA");
   ack_in_frame_a: assert property (
      @(posedge clk_link) disable iff (!nrst) !frame_q |-> !sda_s_oe
   ) else $error("slave drove SDA outside a frame");
   busy_no_ack_a: assert property (
      @(posedge clk_link) disable iff (!nrst) busy_q |-> !sda_s_oe
   ) else $error("slave answered while busy");
   busy_len_a: assert property (
      @(posedge clk_link) disable iff (!nrst) $fell(busy_q) |-> bcnt_q == WR_CYC
   ) else $error("write cycle length wrong");
   busy_after_stop_a: assert property (
      @(posedge clk_link) disable iff (!nrst) $rose(busy_q) |-> age_q <= 4'h6
   ) else $error("write cycle began without a stop");
   busy_out_frame_a: assert property (
      @(posedge clk_link) disable iff (!nrst) $rose(busy_q) |-> !frame_q
   ) else $error("write cycle began inside a frame");
   scl_low_len_a: assert property (
      @(posedge clk_sys) disable iff (!nrst) $fell(scl_oe) |-> hcnt_q >= QTR_CYC
   ) else $error("SCL low phase too short");
   cover property (@(posedge clk_link) disable iff (!nrst) $rose(busy_q));
   cover property (@(posedge clk_link) disable iff (!nrst) scl && sda_s_oe);
   cover property (@(posedge clk_link) disable iff (!nrst) start_ev && frame_q);
endmodule
`default_nettype wire

// [bench/tweep_tb_top.sv]
// Testbench joining the two-wire master and memory slave
`timescale 1ns/10ps
`default_nettype none
module tweep_tb_top;
   // ****************
   // Set-up
   // ****************
   typedef struct {
      tweep_pkg::tweep_op_t op;
      logic [2:0] bank;
      logic [7:0] word;
      logic [7:0] data;
   } tweep_row_t;
   // Outlasts the start of the first poll, ends before the second
   localparam int WR_SIM = 200;
   localparam tweep_pkg::tweep_op_t WR = tweep_pkg::TWEEP_OP_WR;
   localparam tweep_pkg::tweep_op_t CUR = tweep_pkg::TWEEP_OP_CUR;
   localparam tweep_pkg::tweep_op_t RND = tweep_pkg::TWEEP_OP_RND;
   localparam tweep_pkg::tweep_op_t POLL = tweep_pkg::TWEEP_OP_POLL;
   logic clk_sys, clk_link, nrst, req, m_busy, s_busy, done_q, ack_ok_q;
   tweep_pkg::tweep_op_t op;
   logic [2:0] bank;
   logic [7:0] word, wdata, rdata_q;
   int errors, total_checks;
   // Reads carry the expected byte in data
   tweep_row_t rows [9] = '{
      '{WR, 3'h2, 8'h00, 8'h96}, '{WR, 3'h2, 8'h0f, 8'h5a},
      '{CUR, 3'h5, 8'h00, 8'h96}, '{WR, 3'h0, 8'h00, 8'ha5},
      '{WR, 3'h7, 8'hff, 8'h3c}, '{RND, 3'h7, 8'hff, 8'h3c},
      '{CUR, 3'h3, 8'h00, 8'ha5}, '{WR, 3'h2, 8'h10, 8'hc3},
      '{RND, 3'h2, 8'h10, 8'hc3}};
   tweep_if bus_if ();
   tweep_master #(.QTR_CYC(4)) i_tweep_master (.clk_sys(clk_sys),
      .nrst(nrst), .req(req), .op(op), .bank(bank), .word(word),
      .wdata(wdata), .busy_q(m_busy), .done_q(done_q),
      .ack_ok_q(ack_ok_q), .rdata_q(rdata_q), .bus(bus_if.master));
   tweep_slave #(.WR_CYC(WR_SIM)) i_tweep_slave (.clk_link(clk_link),
      .nrst(nrst), .bus(bus_if.slave), .busy_q(s_busy));
   tweep_chk #(.WR_CYC(WR_SIM), .QTR_CYC(4)) i_tweep_chk (
      .clk_sys(clk_sys), .clk_link(clk_link), .nrst(nrst),
      .scl_oe(bus_if.scl_oe), .sda_s_oe(bus_if.sda_s_oe),
      .scl(bus_if.scl), .sda(bus_if.sda), .busy_q(s_busy));
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'h0;
      #7;
      forever #15 clk_link = ~clk_link;
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmd(input tweep_pkg::tweep_op_t o, input logic [2:0] b,
                      input logic [7:0] w, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      #1;
      req = 1'h1;
      op = o;
      bank = b;
      word = w;
      wdata = d;
      @(posedge clk_sys);
      #1;
      req = 1'h0;
      n = 0;
      while (done_q !== 1'b1 && n < 5000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 5000) begin
         errors++;
         $display("unexpected at %0t: command never finished", $time);
      end
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      cmd(POLL, 3'h0, 8'h00, 8'h00);
      while (ack_ok_q !== 1'b1 && k < 8) begin
         cmd(POLL, 3'h0, 8'h00, 8'h00);
         k++;
      end
      check({7'h0, ack_ok_q}, 8'h01);
   endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      errors = 0;
      total_checks = 0;
      {nrst, req, bank, word, wdata} = '0;
      op = WR;
      repeat (12) @(posedge clk_sys);
      check({1'h0, bus_if.scl, bus_if.sda, bus_if.sda_s_oe, s_busy, m_busy,
             done_q, ack_ok_q}, 8'h60);
      check(rdata_q, 8'h00);
      #1;
      nrst = 1'h1;
      repeat (4) @(posedge clk_sys);
      $display("reset test done");
      foreach (rows[i]) begin
         cmd(rows[i].op, rows[i].bank, rows[i].word, rows[i].data);
         check({7'h0, ack_ok_q}, 8'h01);
         if (rows[i].op == WR) begin
            wait_idle();
         end else begin
            check(rdata_q, rows[i].data);
            check({5'h0, bus_if.scl, bus_if.sda, bus_if.sda_s_oe},
                  8'h06);
         end
         $display("row %0d done", i);
      end
      cmd(WR, 3'h4, 8'h44, 8'h77);
      cmd(POLL, 3'h0, 8'h00, 8'h00);
      check({7'h0, ack_ok_q}, 8'h00);
      cmd(POLL, 3'h0, 8'h00, 8'h00);
      check({7'h0, ack_ok_q}, 8'h01);
      cmd(WR, 3'h4, 8'h45, 8'h11);
      cmd(RND, 3'h4, 8'h44, 8'h00);
      check({7'h0, ack_ok_q}, 8'h00);
      wait_idle();
      cmd(RND, 3'h4, 8'h44, 8'h00);
      check(rdata_q, 8'h77);
      cmd(RND, 3'h4, 8'h45, 8'h00);
      check(rdata_q, 8'h11);
      $display("polling test done");
      results();
   end
   initial begin
      #2400000;
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
endmodule
`default_nettype wire

// [rtl/tweep_if.sv]
// Two-wire bus carrier with open-drain resolution
`timescale 1ns/10ps
`default_nettype none
interface tweep_if;
   logic scl_oe;
   logic scl_o;
   logic sda_m_oe;
   logic sda_m_o;
   logic sda_s_oe;
   logic sda_s_o;
   logic scl;
   logic sda;
   // Wired-AND with pull-ups
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
   modport master (
      output scl_oe,
      output scl_o,
      output sda_m_oe,
      output sda_m_o,
      input scl,
      input sda
   );
   modport slave (
      output sda_s_oe,
      output sda_s_o,
      input scl,
      input sda
   );
endinterface
`default_nettype wire

// [rtl/tweep_master.sv]
// Two-wire bus master that makes SCL from the system clock
`timescale 1ns/10ps
`default_nettype none
module tweep_master #(
   parameter int QTR_CYC = tweep_pkg::QTR_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Command
   input wire logic req,
   input wire tweep_pkg::tweep_op_t op,
   input wire logic [2:0] bank,
   input wire logic [7:0] word,
   input wire logic [7:0] wdata,
   // Answer
   output logic busy_q,
   output logic done_q,
   output logic ack_ok_q,
   output logic [7:0] rdata_q,
   // Bus
   tweep_if.master bus
);
   localparam int CW = $clog2(QTR_CYC + 1);
   typedef enum logic [3:0] {
      EL_START = 4'h1,
      EL_TX = 4'h2,
      EL_RX = 4'h4,
      EL_STOP = 4'h8
   } tweep_el_t;

   tweep_pkg::tweep_op_t op_q, op_d;
   tweep_el_t el;
   logic [7:0] txb, aw, ar;
   logic [CW-1:0] tick_q, tick_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] step_q, step_d;
   logic [7:0] sh_q, sh_d, rdata_d;
   logic [2:0] bank_q, bank_d;
   logic [7:0] word_q, word_d, wdata_q, wdata_d;
   logic ab_q, ab_d, ok_d, busy_d, done_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic sda_s1_q, sda_s2_q;
   logic adv, fin;

   assign bus.scl_o = 1'b0;
   assign bus.sda_m_o = 1'b0;
   assign bus.scl_oe = scl_oe_q;
   assign bus.sda_m_oe = sda_oe_q;
   assign aw = {tweep_pkg::DEV_TYPE, bank_q, tweep_pkg::RW_WRITE};
   assign ar = {tweep_pkg::DEV_TYPE, bank_q, tweep_pkg::RW_READ};

   // ************************************
   // Element sequence per command
   // ************************************
   always_comb begin
      el = EL_STOP;
      txb = 8'h00;
      if (ab_q) begin
         el = EL_STOP;
      end else if (step_q == 3'h0 ||
                   (op_q == tweep_pkg::TWEEP_OP_RND && step_q == 3'h3)) begin
         el = EL_START;
      end else if (step_q == 3'h1) begin
         el = EL_TX;
         txb = (op_q == tweep_pkg::TWEEP_OP_CUR) ? ar : aw;
      end else if (step_q == 3'h2 && (op_q == tweep_pkg::TWEEP_OP_WR ||
                                       op_q == tweep_pkg::TWEEP_OP_RND)) begin
         el = EL_TX;
         txb = word_q;
      end else if (step_q == 3'h3 && op_q == tweep_pkg::TWEEP_OP_WR) begin
         el = EL_TX;
         txb = wdata_q;
      end else if (step_q == 3'h4 && op_q == tweep_pkg::TWEEP_OP_RND) begin
         el = EL_TX;
         txb = ar;
      end else if ((step_q == 3'h2 && op_q == tweep_pkg::TWEEP_OP_CUR) ||
                   (step_q == 3'h5 && op_q == tweep_pkg::TWEEP_OP_RND)) begin
         el = EL_RX;
      end
   end

   // ************************************
   // Bit timing and line control
   // ************************************
   always_comb begin
      op_d = op_q;
      bank_d = bank_q;
      word_d = word_q;
      wdata_d = wdata_q;
      tick_d = tick_q;
      ph_d = ph_q;
      bit_d = bit_q;
      step_d = step_q;
      sh_d = sh_q;
      rdata_d = rdata_q;
      ab_d = ab_q;
      ok_d = ack_ok_q;
      busy_d = busy_q;
      done_d = 1'b0;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      adv = (tick_q == CW'(QTR_CYC - 1));
      fin = 1'b0;
      if (!busy_q) begin
         if (req) begin
            busy_d = 1'b1;
            op_d = op;
            bank_d = bank;
            word_d = word;
            wdata_d = wdata;
            step_d = 3'h0;
            ph_d = 2'h0;
            bit_d = 4'h0;
            tick_d = '0;
            ab_d = 1'b0;
            ok_d = 1'b1;
         end
      end else if (!adv) begin
         tick_d = tick_q + 1'b1;
      end else begin
         tick_d = '0;
         ph_d = ph_q + 2'h1;
         unique case (el)
            EL_START: begin
               unique case (ph_q)
                  2'h0: sda_oe_d = 1'b0;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  2'h3: begin
                     scl_oe_d = 1'b1;
                     fin = 1'b1;
                  end
               endcase
            end
            EL_STOP: begin
               unique case (ph_q)
                  2'h0: sda_oe_d = 1'b1;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  2'h3: fin = 1'b1;
               endcase
            end
            EL_TX, EL_RX: begin
               unique case (ph_q)
                  2'h0: begin
                     // SCL is low here
                     sda_oe_d = (el == EL_TX && bit_q < tweep_pkg::ACK_BIT) ?
                        ~txb[3'(4'h7 - bit_q)] : 1'b0;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin
                     if (el == EL_RX && bit_q < tweep_pkg::ACK_BIT) begin
                        sh_d = {sh_q[6:0], sda_s2_q};
                     end
                     if (el == EL_TX && bit_q == tweep_pkg::ACK_BIT &&
                         sda_s2_q) begin
                        ok_d = 1'b0;
                        ab_d = 1'b1;
                     end
                  end
                  2'h3: begin
                     scl_oe_d = 1'b1;
                     if (bit_q == tweep_pkg::ACK_BIT) begin
                        fin = 1'b1;
                        if (el == EL_RX) begin
                           rdata_d = sh_q;
                        end
                     end else begin
                        bit_d = bit_q + 4'h1;
                     end
                  end
               endcase
            end
            default: fin = 1'b1;
         endcase
         if (fin) begin
            bit_d = 4'h0;
            step_d = step_q + 3'h1;
            if (el == EL_STOP) begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         op_q <= tweep_pkg::TWEEP_OP_WR;
         bank_q <= 3'h0;
         word_q <= 8'h00;
         wdata_q <= 8'h00;
         tick_q <= '0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         step_q <= 3'h0;
         sh_q <= 8'h00;
         rdata_q <= 8'h00;
         ab_q <= 1'b0;
         ack_ok_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
         op_q <= op_d;
         bank_q <= bank_d;
         word_q <= word_d;
         wdata_q <= wdata_d;
         tick_q <= tick_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         step_q <= step_d;
         sh_q <= sh_d;
         rdata_q <= rdata_d;
         ab_q <= ab_d;
         ack_ok_q <= ok_d;
         busy_q <= busy_d;
         done_q <= done_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
      end
   end
endmodule
`default_nettype wire

// [rtl/tweep_pkg.sv]
// Shared constants for the two-wire memory slave and its bus master
`default_nettype none
package tweep_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 11;
   localparam int BANK_W = 3;
   localparam int PAGE_W = 4;
   localparam int MEM_DEPTH = 2048;
   // Device type code; value is arbitrary
   localparam logic [3:0] DEV_TYPE = 4'h5;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] END_BIT = 4'h9;
   localparam logic RW_READ = 1'h1;
   localparam logic RW_WRITE = 1'h0;
   // Timing
   localparam int T_WR_MS = 5;
   localparam int LINK_PERIOD_NS = 30;
   localparam int WR_CYC = T_WR_MS * 1000000 / LINK_PERIOD_NS;
   localparam int T_SCL_NS = 10000;
   localparam int SYS_PERIOD_NS = 40;
   localparam int QTR_CYC =
      (T_SCL_NS + 4 * SYS_PERIOD_NS - 1) / (4 * SYS_PERIOD_NS);
   // Master commands
   typedef enum logic [1:0] {
      TWEEP_OP_WR = 2'h0,
      TWEEP_OP_CUR = 2'h1,
      TWEEP_OP_RND = 2'h2,
      TWEEP_OP_POLL = 2'h3
   } tweep_op_t;
endpackage
`default_nettype wire

// [rtl/tweep_slave.sv]
// Two-wire serial memory slave, clocked by the link clock
`timescale 1ns/10ps
`default_nettype none
module tweep_slave #(
   parameter int WR_CYC = tweep_pkg::WR_CYC
) (
   // Clock and reset
   input wire logic clk_link,
   input wire logic nrst,
   // Bus
   tweep_if.slave bus,
   // Status
   output logic busy_q
);
   localparam int TW = $clog2(WR_CYC + 1);

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ADDR = 5'h02,
      S_WORD = 5'h04,
      S_WDATA = 5'h08,
      S_RDATA = 5'h10
   } tweep_dst_t;

   logic [tweep_pkg::DATA_W-1:0] mem [tweep_pkg::MEM_DEPTH];
   logic scl_s1_q, scl_s2_q, scl_p_q;
   logic sda_s1_q, sda_s2_q, sda_p_q;
   logic start_w, stop_w, rise_w, fall_w;
   tweep_dst_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [tweep_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [tweep_pkg::BANK_W-1:0] bank_q, bank_d;
   logic rw_q, rw_d;
   logic sel_q, sel_d;
   logic mack_q, mack_d;
   logic pend_q, pend_d;
   logic oe_q, oe_d;
   logic busy_d;
   logic [TW-1:0] tmr_q, tmr_d;
   logic mem_we;
   logic match_w;
   logic [7:0] rd_byte;

   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = oe_q;

   // ************************************
   // Line synchronisers
   // ************************************
   always_ff @(posedge clk_link or negedge nrst) begin
      if (!nrst) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s1_q <= bus.scl;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
      end
   end

   assign start_w = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   assign stop_w = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   assign rise_w = scl_s2_q & ~scl_p_q;
   assign fall_w = ~scl_s2_q & scl_p_q;
   assign match_w = (sh_q[7:4] == tweep_pkg::DEV_TYPE);
   assign rd_byte = mem[addr_q];

   // ************************************
   // Protocol engine
   // ************************************
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      addr_d = addr_q;
      bank_d = bank_q;
      rw_d = rw_q;
      sel_d = sel_q;
      mack_d = mack_q;
      pend_d = pend_q;
      oe_d = oe_q;
      busy_d = busy_q;
      tmr_d = tmr_q;
      mem_we = 1'b0;
      if (busy_q) begin
         tmr_d = tmr_q - 1'b1;
         if (tmr_q == TW'(1)) begin
            busy_d = 1'b0;
         end
      end
      if (busy_q) begin
         // Deaf while writing, so polling sees no ack
         st_d = S_IDLE;
         oe_d = 1'b0;
      end else if (start_w) begin
         st_d = S_ADDR;
         bit_d = 4'h0;
         oe_d = 1'b0;
         sel_d = 1'b0;
      end else if (stop_w) begin
         st_d = S_IDLE;
         bit_d = 4'h0;
         oe_d = 1'b0;
         if (pend_q) begin
            busy_d = 1'b1;
            tmr_d = TW'(WR_CYC);
            pend_d = 1'b0;
         end
      end else if (rise_w && st_q != S_IDLE) begin
         if (bit_q < tweep_pkg::ACK_BIT && st_q != S_RDATA) begin
            sh_d = {sh_q[6:0], sda_s2_q};
         end
         if (bit_q == tweep_pkg::ACK_BIT) begin
            mack_d = ~sda_s2_q;
         end
         if (bit_q != tweep_pkg::END_BIT) begin
            bit_d = bit_q + 4'h1;
         end
      end else if (fall_w && bit_q == tweep_pkg::ACK_BIT) begin
         unique case (st_q)
            S_ADDR: begin
               sel_d = match_w;
               rw_d = sh_q[0];
               bank_d = sh_q[3:1];
               oe_d = match_w;
            end
            S_WORD: begin
               addr_d = {bank_q, sh_q};
               oe_d = 1'b1;
            end
            S_WDATA: begin
               mem_we = 1'b1;
               addr_d = {addr_q[tweep_pkg::ADDR_W-1:tweep_pkg::PAGE_W],
                         addr_q[tweep_pkg::PAGE_W-1:0] + 4'h1};
               pend_d = 1'b1;
               oe_d = 1'b1;
            end
            S_RDATA: begin
               oe_d = 1'b0;
            end
            S_IDLE: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = S_IDLE;
            end
         endcase
      end else if (fall_w && bit_q == tweep_pkg::END_BIT) begin
         bit_d = 4'h0;
         oe_d = 1'b0;
         unique case (st_q)
            S_ADDR: begin
               if (!sel_q) begin
                  st_d = S_IDLE;
               end else if (rw_q == tweep_pkg::RW_READ) begin
                  st_d = S_RDATA;
                  sh_d = rd_byte;
                  oe_d = ~rd_byte[7];
                  addr_d = addr_q + 11'h001;
               end else begin
                  st_d = S_WORD;
               end
            end
            S_WORD: begin
               st_d = S_WDATA;
            end
            S_WDATA: begin
               st_d = S_WDATA;
            end
            S_RDATA: begin
               if (mack_q) begin
                  sh_d = rd_byte;
                  oe_d = ~rd_byte[7];
                  addr_d = addr_q + 11'h001;
               end else begin
                  st_d = S_IDLE;
               end
            end
            S_IDLE: begin
               st_d = S_IDLE;
            end
            default: begin
               st_d = S_IDLE;
            end
         endcase
      end else if (fall_w && st_q == S_RDATA && bit_q != 4'h0) begin
         sh_d = {sh_q[6:0], 1'b0};
         oe_d = ~sh_q[6];
      end
   end

   always_ff @(posedge clk_link or negedge nrst) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         addr_q <= 11'h000;
         bank_q <= 3'h0;
         rw_q <= 1'b0;
         sel_q <= 1'b0;
         mack_q <= 1'b0;
         pend_q <= 1'b0;
         oe_q <= 1'b0;
         busy_q <= 1'b0;
         tmr_q <= '0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         bank_q <= bank_d;
         rw_q <= rw_d;
         sel_q <= sel_d;
         mack_q <= mack_d;
         pend_q <= pend_d;
         oe_q <= oe_d;
         busy_q <= busy_d;
         tmr_q <= tmr_d;
      end
   end

   // ************************************
   // Array
   // ************************************
   always_ff @(posedge clk_link) begin
      if (mem_we) begin
         mem[addr_q] <= sh_q;
      end
   end
endmodule
`default_nettype wire
